// >>> common/sli_consts.vh
// Constants for the status lamp indicator: register map, fields, resets, timing.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef SLI_CONSTS_VH
`define SLI_CONSTS_VH

// Register byte offsets
`define SLI_REG_CTRL 4'h0
`define SLI_REG_STAT 4'h4
`define SLI_REG_RATE 4'h8

// Control field positions
`define SLI_CTRL_MODE_LSB 0
`define SLI_CTRL_MODE_MSB 2
`define SLI_CTRL_TRIG_LSB 4
`define SLI_CTRL_TRIG_MSB 5
`define SLI_CTRL_MATCH_BIT 8
`define SLI_CTRL_RST 32'h0000_0000

// Operating modes
`define SLI_MODE_START 3'h0
`define SLI_MODE_READ 3'h1
`define SLI_MODE_QUAL 3'h2
`define SLI_MODE_PROF 3'h3
`define SLI_MODE_AUTO 3'h4
`define SLI_MODE_ADJ 3'h5
`define SLI_MODE_MASK 3'h6

// Trigger variants in reading mode
`define SLI_TRIG_EXT 2'h0
`define SLI_TRIG_FREE 2'h1
`define SLI_TRIG_CONT 2'h2
`define SLI_TRIG_REFL 2'h3

// Timing
`define SLI_CLK_HZ 50000000
`define SLI_WAIT_S 5
`define SLI_WAIT_CYC (`SLI_CLK_HZ * `SLI_WAIT_S)
`define SLI_BLINK2_HZ 2
`define SLI_BLINK5_HZ 5
`define SLI_HALF2_CYC (`SLI_CLK_HZ / (2 * `SLI_BLINK2_HZ))
`define SLI_HALF5_CYC (`SLI_CLK_HZ / (2 * `SLI_BLINK5_HZ))
`define SLI_FLICK_US 20000
`define SLI_FLICK_CYC (`SLI_CLK_HZ / 1000000 * `SLI_FLICK_US)
`define SLI_REFL_SCANS 20

// Reading-rate thresholds in percent
`define SLI_RATE_LO 7'd30
`define SLI_RATE_MID 7'd70
`define SLI_RATE_HI 7'd90

`endif

// >>> rtl/sli_status_lamp.v
// Status lamp indicator: drives four front-panel lamps from internal status.
// Assumes all inputs synchronous to aclk; registers over AXI4-Lite.
// Operation
// - Four lamps: ready, emitter active, result status, host data activity.
// - At startup, ready lamp lights after self-test pass and wait expiry.
// - During startup, emitter lamp follows emitter while reading profile codes.
// - Reading mode: ready lamp steady; dark in any other mode except startup.
// - External trigger: emitter lamp follows trigger-switched emitter state.
// - Self-triggered and uninterrupted scan: emitter lamp constantly lit.
// - Reflector-presence trigger: emitter lamp lit once every twentieth scan.
// - Reading mode: result lamp mirrors second result output pulse.
// - Default selection: result lamp lights after each good read.
// - Match enabled on second output: lamp lights on match-code equality.
// - Data lamp flickers while transmitting to host.
// - Quality mode: result dark below 30 percent, steady above 90.
// - Quality mode: blink 2 Hz for 30-70, 5 Hz for 70-90 percent.
// - Quality and adjusting modes: emitter lamp constantly lit.
// - Profile and auto configuration: emitter lamp lit while codes read.
// - Masking display: emitter lamp alternates at masking frequency.
// - Wait five seconds after power-up before reading mode; code gates only the startup ready lamp.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "sli_consts.vh"

module sli_status_lamp #(
	// Power-up wait for profile codes, in cycles
	parameter WAIT_CYC = `SLI_WAIT_CYC,
	// Half periods of the slow and fast blink, in cycles
	parameter HALF2_CYC = `SLI_HALF2_CYC,
	parameter HALF5_CYC = `SLI_HALF5_CYC,
	// Data lamp stretch per character, in cycles
	parameter FLICK_CYC = `SLI_FLICK_CYC,
	// Scans between reflector-mode emitter flashes
	parameter REFL_SCANS = `SLI_REFL_SCANS
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address and data
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Internal status inputs
	input wire selftest_pass,
	input wire emitter_active,
	input wire scan_tick,
	input wire result2_out,
	input wire host_tx_char,
	input wire mask_phase,
	input wire [6:0] read_rate,
	// Lamp drives
	output reg lamp_ready,
	output reg lamp_emitter,
	output reg lamp_result,
	output reg lamp_data
);

	// Register map, one aligned word each
	//   0x0 control, read/write: mode [2:0], trigger [5:4], match enable [8]
	//   0x4 status, read-only: lamps [3:0], self-test [4], wait done [5]
	//   0x8 reading rate, read-only: percent [6:0]
	//   Any other offset answers with a slave error
	// Mode codes
	//   0 startup, 1 reading, 2 quality, 3 profile, 4 auto configuration
	//   5 adjusting, 6 masking display, 7 ready, emitter and result lamps dark (data lamp still flickers)
	// Trigger codes, reading mode only
	//   0 external, 1 self-triggered, 2 uninterrupted scan, 3 reflector
	// Match enable is kept for software only: the second result output
	//   already carries the chosen status and its pulse length
	// Reset value all zero: startup mode, external trigger
	// Control writes reach the lamps one cycle after the write edge
	// Internal state; software sees only ctrl_q and wait_done_q
	reg [31:0] ctrl_q;
	reg [31:0] wait_cnt_q;
	reg wait_done_q;
	reg [31:0] blink2_cnt_q;
	reg [31:0] blink5_cnt_q;
	reg blink2_q;
	reg blink5_q;
	reg [31:0] flick_cnt_q;
	reg [4:0] scan_cnt_q;
	reg refl_lamp_q;
	reg aw_held_q;
	reg w_held_q;
	reg [3:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	wire [2:0] mode = ctrl_q[`SLI_CTRL_MODE_MSB:`SLI_CTRL_MODE_LSB];
	wire [1:0] trig = ctrl_q[`SLI_CTRL_TRIG_MSB:`SLI_CTRL_TRIG_LSB];

	// Merge bytes by strobe
	// Unstrobed lanes keep their old contents
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// Half-period counter step, 50 percent duty square wave
	// Counts 0 to half-1, so the toggle lands on every half-th edge
	function [31:0] step;
		input [31:0] cnt;
		input [31:0] half;
		begin
			if (cnt >= half - 32'h1)
				step = 32'h0;
			else
				step = cnt + 32'h1;
		end
	endfunction

	// Write channel: address and data taken in either order
	// Both readies drop while a response waits, so a second write
	// cannot overtake one the host has not yet acknowledged.
	// Read-only words accept writes and ignore them, so a host that
	// sweeps the map sees OKAY there and an error only off the map.
	wire wr_go = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
	wire [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			ctrl_q <= `SLI_CTRL_RST;
		end else begin
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wr_addr == `SLI_REG_CTRL) begin
					ctrl_q <= merge(ctrl_q, wr_data, wr_strb);
					s_axi_bresp <= 2'h0;
				end else if (wr_addr == `SLI_REG_STAT || wr_addr == `SLI_REG_RATE) begin
					s_axi_bresp <= 2'h0; // Read-only, write ignored
				end else begin
					s_axi_bresp <= 2'h2; // Unmapped: slave error
				end
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_q <= 1'b1;
					awaddr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_q <= 1'b1;
					wdata_q <= s_axi_wdata;
					wstrb_q <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one-cycle answer
	// Status is built from the registered lamps, so software sees
	// exactly what the panel shows
	// Unmapped reads return zero with a slave error
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				`SLI_REG_CTRL: s_axi_rdata <= ctrl_q;
				`SLI_REG_STAT: s_axi_rdata <= {26'h0, wait_done_q, selftest_pass,
					lamp_data, lamp_result, lamp_emitter, lamp_ready};
				`SLI_REG_RATE: s_axi_rdata <= {25'h0, read_rate};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Power-up wait for profile codes
	// Counter stops once done: no wrap, so the ready lamp cannot
	// drop again after a long uptime
	// Restarts with every reset, as a fresh power-up would
	always @(posedge aclk) begin
		if (!aresetn) begin
			wait_cnt_q <= 32'h0;
			wait_done_q <= 1'b0;
		end else if (!wait_done_q) begin
			if (wait_cnt_q >= WAIT_CYC - 1)
				wait_done_q <= 1'b1;
			else
				wait_cnt_q <= wait_cnt_q + 32'h1;
		end
	end

	// Blink generators, free running so both rates stay phase-stable
	// Limitation: a mode switch may start mid-period; the eye
	// does not notice, and no restart logic is needed
	// Both run in every mode, traded for a few idle flip-flops
	always @(posedge aclk) begin
		if (!aresetn) begin
			blink2_cnt_q <= 32'h0;
			blink5_cnt_q <= 32'h0;
			blink2_q <= 1'b0;
			blink5_q <= 1'b0;
		end else begin
			blink2_cnt_q <= step(blink2_cnt_q, HALF2_CYC);
			blink5_cnt_q <= step(blink5_cnt_q, HALF5_CYC);
			if (blink2_cnt_q >= HALF2_CYC - 1)
				blink2_q <= !blink2_q;
			if (blink5_cnt_q >= HALF5_CYC - 1)
				blink5_q <= !blink5_q;
		end
	end

	// Flicker stretch, retriggered per transmitted character
	// Lamp is lit for the stretch after each character; gaps
	// between characters make the flicker. A dense stream closer
	// than the stretch reads as steady, which is the intended cue
	always @(posedge aclk) begin
		if (!aresetn)
			flick_cnt_q <= 32'h0;
		else if (host_tx_char)
			flick_cnt_q <= FLICK_CYC;
		else if (flick_cnt_q != 32'h0)
			flick_cnt_q <= flick_cnt_q - 32'h1;
	end

	// Every twentieth scan lights the emitter lamp for one scan period
	// Lamp holds until the next tick, roughly one scan, so the faint
	// line shows as a short flash on the panel
	// Count keeps running outside reflector mode; phase is not restarted
	always @(posedge aclk) begin
		if (!aresetn) begin
			scan_cnt_q <= 5'h0;
			refl_lamp_q <= 1'b0;
		end else if (scan_tick) begin
			if (scan_cnt_q == REFL_SCANS - 1) begin
				scan_cnt_q <= 5'h0;
				refl_lamp_q <= 1'b1;
			end else begin
				scan_cnt_q <= scan_cnt_q + 5'h1;
				refl_lamp_q <= 1'b0;
			end
		end
	end

	// Lamp drive selection
	// Self-triggered modes force the emitter lamp on, since the
	// emitter never switches off there. Quality bands: below 30 dark,
	// 30 to 69 slow blink, 70 to 90 fast blink, above 90 steady
	reg ready_d;
	reg emit_d;
	reg result_d;
	always @* begin
		ready_d = 1'b0;
		emit_d = 1'b0;
		result_d = 1'b0;
		case (mode)
			`SLI_MODE_START: begin
				ready_d = selftest_pass && wait_done_q;
				emit_d = emitter_active;
			end
			`SLI_MODE_READ: begin
				ready_d = 1'b1;
				// Result 2 already carries good-read or match status and pulse length
				result_d = result2_out;
				case (trig)
					`SLI_TRIG_EXT: emit_d = emitter_active;
					`SLI_TRIG_FREE: emit_d = 1'b1;
					`SLI_TRIG_CONT: emit_d = 1'b1;
					`SLI_TRIG_REFL: emit_d = refl_lamp_q;
					default: emit_d = emitter_active;
				endcase
			end
			`SLI_MODE_QUAL: begin
				emit_d = 1'b1;
				if (read_rate < `SLI_RATE_LO)
					result_d = 1'b0;
				else if (read_rate < `SLI_RATE_MID)
					result_d = blink2_q;
				else if (read_rate <= `SLI_RATE_HI)
					result_d = blink5_q;
				else
					result_d = 1'b1;
			end
			`SLI_MODE_ADJ: emit_d = 1'b1;
			`SLI_MODE_PROF: emit_d = emitter_active;
			`SLI_MODE_AUTO: emit_d = emitter_active;
			`SLI_MODE_MASK: emit_d = mask_phase;
			default: begin
				ready_d = 1'b0;
			end
		endcase
	end

	// Registered lamp outputs
	// One cycle of latency buys glitch-free pins while the mode
	// word or the inputs change
	// Data lamp follows the stretch alone, so it scales with FLICK_CYC
	always @(posedge aclk) begin
		if (!aresetn) begin
			lamp_ready <= 1'b0;
			lamp_emitter <= 1'b0;
			lamp_result <= 1'b0;
			lamp_data <= 1'b0;
		end else begin
			lamp_ready <= ready_d;
			lamp_emitter <= emit_d;
			lamp_result <= result_d;
			lamp_data <= (flick_cnt_q != 32'h0);
		end
	end

endmodule // sli_status_lamp

// >>> tb/sli_lamp_asserts.sv
// Port checker for the status lamp block.
// Assumes control writes offer address and data together.
`timescale 1ns/1ns
module sli_lamp_chk #(parameter WAIT_CYC = 50) (
	// Clock, reset
	input wire aclk,
	input wire aresetn,
	// Control writes
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	// Status in, lamps out
	input wire selftest_pass,
	input wire emitter_active,
	input wire result2_out,
	input wire mask_phase,
	input wire [6:0] read_rate,
	input wire lamp_ready,
	input wire lamp_emitter,
	input wire lamp_result
);
	reg [31:0] up_q = 32'h0;
	reg [5:0] ctl_q = 6'h0;
	// Uptime and a shadow of mode and trigger; split writes are not tracked
	always @(posedge aclk) begin
		up_q <= aresetn ? up_q + {31'h0, ~&up_q} : 32'h0;
		if (!aresetn)
			ctl_q <= 6'h0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 4'h0)
			ctl_q <= s_axi_wdata[5:0];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wait_gate_a: assert property (lamp_ready |-> up_q > WAIT_CYC)
		else $error("ready lamp early");
	self_gate_a: assert property (lamp_ready && $past(ctl_q[2:0]) == 3'h0 |-> $past(selftest_pass))
		else $error("ready lamp without self-test");
	ready_mode_a: assert property (lamp_ready |-> $past(ctl_q[2:0]) <= 3'h1)
		else $error("ready lamp in other mode");
	emit_follow_a: assert property ($past(ctl_q[2:0]) inside {3'h0, 3'h3, 3'h4} || $past(ctl_q) == 6'h01
		|-> lamp_emitter == $past(emitter_active)) else $error("emitter lamp off emitter");
	emit_on_a: assert property ($past(ctl_q) inside {6'h11, 6'h21} || $past(ctl_q[2:0]) inside {3'h2, 3'h5}
		|-> lamp_emitter) else $error("emitter lamp not steady");
	mask_blink_a: assert property ($past(ctl_q[2:0]) == 3'h6 |-> lamp_emitter == $past(mask_phase))
		else $error("emitter lamp off mask phase");
	res_mirror_a: assert property ($past(ctl_q[2:0]) == 3'h1 |-> lamp_result == $past(result2_out))
		else $error("result lamp off output");
	qual_band_a: assert property ($past(ctl_q[2:0]) == 3'h2 && ($past(read_rate) < 30 || $past(read_rate) > 90)
		|-> lamp_result == ($past(read_rate) > 90)) else $error("result lamp band");
endmodule // sli_lamp_chk

// >>> tb/sli_lamp_model.sv
// Lamp panel model: counts lamp changes as an eye would.
// Assumes active high, registered lamp drives.
`timescale 1ns/1ns
module sli_lamp_model (
	// Clock
	input wire aclk,
	// Lamp drives
	input wire lamp_emitter,
	input wire lamp_result,
	// Change counts
	output reg [15:0] emi_flips = 16'h0,
	output reg [15:0] res_flips = 16'h0
);
	reg emi_q = 1'b0;
	reg res_q = 1'b0;
	// Each on or off change counts once; unknown counts as a change
	always @(posedge aclk) begin
		emi_q <= lamp_emitter;
		res_q <= lamp_result;
		emi_flips <= emi_flips + {15'h0, lamp_emitter !== emi_q};
		res_flips <= res_flips + {15'h0, lamp_result !== res_q};
	end
endmodule // sli_lamp_model

// >>> tb/test_status_lamp_indicator.sv
// Bench for the status lamp block: bus tasks, lamp scenarios.
// Assumes short wait and blink counts set below.
`timescale 1ns/1ns
module test_status_lamp_indicator;
	reg aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, selftest_pass = 1'b0, emitter_active = 1'b0;
	reg scan_tick = 1'b0, result2_out = 1'b0, mask_phase = 1'b0, host_tx_char = 1'b0;
	reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	reg [31:0] s_axi_wdata = 32'h0, d, f;
	reg [6:0] read_rate = 7'h0;
	reg [1:0] r;
	reg [2:0] m;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lamp_ready, lamp_emitter, lamp_result;
	wire lamp_data;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] ef, rf;
	integer errors = 0, comparisons = 0, i;
	// 50 MHz clock
	initial forever #10 aclk = ~aclk;
	sli_status_lamp #(.WAIT_CYC(50), .HALF2_CYC(10), .HALF5_CYC(4), .FLICK_CYC(8)) dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .selftest_pass, .emitter_active, .scan_tick,
		.result2_out, .host_tx_char, .mask_phase, .read_rate, .lamp_ready, .lamp_emitter, .lamp_result,
		.lamp_data);
	sli_lamp_model lamps (.aclk, .lamp_emitter, .lamp_result, .emi_flips(ef), .res_flips(rf));
	task chk(input [31:0] s, input [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				errors = errors + 1;
				$display("[ERR] %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge aclk);
	endtask
	// Write: both channels offered at once, each dropped when taken
	task wr(input [3:0] a, input [31:0] v);
		reg ta, tw;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			ta = 1'b0;
			tw = 1'b0;
			while (!(ta && tw)) begin
				cyc(1);
				ta = ta || s_axi_awready;
				tw = tw || s_axi_wready;
				@(posedge aclk);
				if (ta)
					s_axi_awvalid <= 1'b0;
				if (tw)
					s_axi_wvalid <= 1'b0;
			end
			cyc(1);
			while (s_axi_bvalid !== 1'b1)
				cyc(1);
			r = s_axi_bresp;
			@(posedge aclk);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			cyc(1);
			while (s_axi_arready !== 1'b1)
				cyc(1);
			@(posedge aclk);
			s_axi_arvalid <= 1'b0;
			cyc(1);
			while (s_axi_rvalid !== 1'b1)
				cyc(1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			s_axi_rready <= 1'b0;
		end
	endtask
	task end_sim;
		begin
			$display("errors %0d comparisons %0d", errors, comparisons);
			if (errors == 0 && comparisons > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// Main sequence; rate table holds band edges and expected changes in 80 cycles
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h4);
		chk(d, 32'h0);
		@(posedge aclk);
		emitter_active <= 1'b1;
		cyc(2);
		chk({lamp_ready, lamp_emitter}, 32'h1);
		@(posedge aclk);
		emitter_active <= 1'b0;
		selftest_pass <= 1'b1;
		cyc(60);
		chk(lamp_ready, 32'h1);
		wr(4'h0, 32'h101);
		@(posedge aclk);
		emitter_active <= 1'b1;
		result2_out <= 1'b1;
		cyc(2);
		chk({lamp_ready, lamp_emitter, lamp_result}, 32'h7);
		@(posedge aclk);
		emitter_active <= 1'b0;
		result2_out <= 1'b0;
		cyc(2);
		chk({lamp_ready, lamp_emitter, lamp_result}, 32'h4);
		for (i = 1; i < 3; i = i + 1) begin
			wr(4'h0, {26'h0, i[1:0], 4'h1});
			cyc(2);
			chk(lamp_emitter, 32'h1);
		end
		wr(4'h0, 32'h31);
		cyc(2);
		f = ef;
		repeat (41) begin
			@(posedge aclk);
			scan_tick <= 1'b1;
			@(posedge aclk);
			scan_tick <= 1'b0;
			@(posedge aclk);
		end
		cyc(2);
		chk(ef - f, 32'h4);
		wr(4'h0, 32'h2);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge aclk);
			read_rate <= i[1] ? (i[0] ? 7'd90 : 7'd30) : (i[0] ? 7'd91 : 7'd29);
			cyc(3);
			f = rf;
			cyc(80);
			chk(rf - f, i[1] ? (i[0] ? 32'd20 : 32'd8) : 32'd0);
			chk(lamp_emitter, 32'h1);
		end
		rd(4'h8);
		chk(d, 32'd90);
		wr(4'h0, 32'h5);
		cyc(2);
		chk(lamp_emitter, 32'h1);
		for (i = 0; i < 6; i = i + 1) begin
			m = i < 2 ? 3'h3 : (i < 4 ? 3'h4 : 3'h6);
			wr(4'h0, {29'h0, m});
			@(posedge aclk);
			emitter_active <= i[0];
			mask_phase <= ~i[0];
			cyc(2);
			chk(lamp_emitter, i[0] ^ (m == 3'h6));
		end
		wr(4'h0, 32'h7);
		cyc(2);
		chk(lamp_ready, 32'h0);
		rd(4'h0);
		chk(d, 32'h7);
		rd(4'hc);
		chk({d[29:0], r}, 32'h2);
		wr(4'hc, 32'h1);
		chk(r, 32'h2);
		@(posedge aclk);
		host_tx_char <= 1'b1;
		@(posedge aclk);
		host_tx_char <= 1'b0;
		cyc(2);
		chk(lamp_data, 32'h1);
		cyc(7);
		chk(lamp_data, 32'h1);
		cyc(1);
		chk(lamp_data, 32'h0);
		end_sim;
	end
	// Watchdog: the run needs about 630 cycles
	initial begin
		#200000;
		errors = errors + 1;
		end_sim;
	end
endmodule // test_status_lamp_indicator
bind sli_status_lamp sli_lamp_chk #(.WAIT_CYC(WAIT_CYC)) u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .selftest_pass, .emitter_active, .result2_out,
	.mask_phase, .read_rate, .lamp_ready, .lamp_emitter, .lamp_result);
